// ---- shared/slm_consts.vh ----
// register map, field positions and reset values of the lane monitor
`ifndef SLM_CONSTS_VH
`define SLM_CONSTS_VH

// ==========================================
// bus geometry
`define SLM_ADDR_W 16
`define SLM_IDX_W 11
`define SLM_RESP_OKAY 2'h0
`define SLM_RESP_SLVERR 2'h2

// ==========================================
// register indices, byte address is four times the index
`define SLM_IDX_ERR_SEL 11'h46B
`define SLM_IDX_DISP 11'h46D
`define SLM_IDX_NIT 11'h46E
`define SLM_IDX_UCC 11'h46F
`define SLM_IDX_CGS 11'h470
`define SLM_IDX_FRS 11'h471
`define SLM_IDX_CKS 11'h472
`define SLM_IDX_IRQ_EN 11'h47A
`define SLM_IDX_THR 11'h47C
`define SLM_IDX_IRQ_STAT 11'h480
`define SLM_IDX_IRQ_CLR 11'h481

// ==========================================
// lane control fields
`define SLM_CTL_IRQ_CLR 7
`define SLM_CTL_CNT_OFF 6
`define SLM_CTL_CNT_CLR 5
`define SLM_CTL_LANE_HI 2
`define SLM_CTL_LANE_LO 0
`define SLM_FLAG_IRQ_CLR 7

// ==========================================
// counter readback selector fields and type codes
`define SLM_SEL_LANE_HI 6
`define SLM_SEL_LANE_LO 4
`define SLM_SEL_TYPE_HI 1
`define SLM_SEL_TYPE_LO 0
`define SLM_TYPE_DISP 2'h0
`define SLM_TYPE_NIT 2'h1
`define SLM_TYPE_UCC 2'h2

// ==========================================
// interrupt status and enable bit positions
`define SLM_INT_DISP 7
`define SLM_INT_NIT 6
`define SLM_INT_UCC 5
`define SLM_INT_CKS 2
`define SLM_INT_FRS 1
`define SLM_INT_CGS 0

// ==========================================
// reset values and counter limits
`define SLM_THR_RST 8'hFF
`define SLM_EN_RST 8'h00
`define SLM_SEL_RST 8'h00
`define SLM_CNT_MAX 8'hFF

`endif

// ---- hw/slm_lane_monitor.v ----
// per-lane error counters, sync status flags and axi4-lite register slave
// Summary of operation
// - control bit 7 clears addressed lane interrupt
// - control bit 6 disables addressed lane counter
// - control bit 5 zeroes addressed lane counter
// - bits 2:0 pick lane; 4:3 are ignored
// - table-miss read shows lanes at threshold
// - control-char read shows lanes at threshold
// - code-group flags show live lane lock
// - any code-group loss raises sync request
// - flag bit 7 write clears its interrupt
// - code-group enable bit 0, checksum bit 2
// - frame flags show live frame lock
// - frame loss starts resync automatically
// - checksum flags show last checksum matched
// - disparity read shows lanes at threshold
// - enabled threshold events pull interrupt low
// - selector 00/01/10 reads lane count
//
// Local design decision: register access over AXI4-Lite.
`include "slm_consts.vh"
`default_nettype none

// ==========================================
// one error type across eight lanes
module slm_err_type (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] err_evt,
  input wire ctl_we,
  input wire [7:0] ctl_data,
  input wire [7:0] thr,
  output wire [7:0] reach,
  output wire [7:0] lane_irq,
  output wire [63:0] counts
);
  wire [7:0] lane_hit;
  // lane field decodes the target lane
  assign lane_hit = ctl_we ?
    (8'h01 << ctl_data[`SLM_CTL_LANE_HI:`SLM_CTL_LANE_LO]) : 8'h00;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lane
      reg [7:0] cnt_r;
      reg off_r;
      reg irq_r;
      wire bump;
      wire [8:0] inc9;
      wire hit_thr;

      // saturate so a stuck lane never wraps past the threshold
      assign bump = err_evt[g] && !off_r && (cnt_r != `SLM_CNT_MAX);
      assign inc9 = {1'b0, cnt_r} + 9'h001;
      assign hit_thr = bump && (inc9[7:0] == thr);

      // counter, disable and per-lane interrupt flag
      always @(posedge aclk) begin
        if (!aresetn) begin
          cnt_r <= 8'h00;
          off_r <= 1'b0;
          irq_r <= 1'b0;
        end else begin
          if (lane_hit[g] && ctl_data[`SLM_CTL_CNT_CLR]) begin
            cnt_r <= 8'h00;
          end else if (bump) begin
            cnt_r <= inc9[7:0];
          end
          if (lane_hit[g] && ctl_data[`SLM_CTL_CNT_OFF]) begin
            off_r <= 1'b1;
          end
          // clear loses to a fresh threshold hit
          if (hit_thr) begin
            irq_r <= 1'b1;
          end else if (lane_hit[g] && ctl_data[`SLM_CTL_IRQ_CLR]) begin
            irq_r <= 1'b0;
          end
        end
      end

      // threshold reached, readable as a status vector
      assign reach[g] = (cnt_r >= thr);
      assign lane_irq[g] = irq_r;
      assign counts[g*8 +: 8] = cnt_r;
    end
  endgenerate
endmodule

// ==========================================
// top: register slave and link status
module slm_lane_monitor (
  input wire aclk,
  input wire aresetn,
  input wire [`SLM_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`SLM_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] bad_disparity_error,
  input wire [7:0] not_in_table_error,
  input wire [7:0] unexpected_control_char_error,
  input wire [7:0] code_group_lock,
  input wire [7:0] frame_lock,
  input wire [7:0] checksum_ok,
  output reg sync_request_n,
  output reg resync_start,
  output reg irq_n
);
  // ==========================================
  // declarations
  reg aw_ok_r;
  reg w_ok_r;
  reg [`SLM_IDX_W-1:0] aw_idx_r;
  reg [7:0] wdata_r;
  reg wlane_r;
  reg [7:0] thr_r;
  reg [7:0] en_r;
  reg [7:0] sel_r;
  reg [2:0] stat_r;
  reg [7:0] cg_r;
  reg [7:0] fr_r;
  reg [7:0] ck_r;
  reg [7:0] rd_nxt;
  reg rd_hit;
  reg wr_hit;
  wire wr_go;
  wire [`SLM_IDX_W-1:0] ar_idx;
  wire [7:0] disp_reach;
  wire [7:0] nit_reach;
  wire [7:0] ucc_reach;
  wire [7:0] disp_irq;
  wire [7:0] nit_irq;
  wire [7:0] ucc_irq;
  wire [63:0] disp_cnt;
  wire [63:0] nit_cnt;
  wire [63:0] ucc_cnt;
  wire [7:0] stat_all;
  wire [7:0] sel_cnt;
  wire [5:0] sel_base;
  wire cg_loss;
  wire fr_loss;
  wire ck_bad;
  wire wr_disp;
  wire wr_nit;
  wire wr_ucc;
  wire flag_clr_cg;
  wire flag_clr_fr;
  wire flag_clr_ck;
  wire [2:0] clr_bits;

  // ==========================================
  // write channel
  // address and data are caught separately, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_idx_r <= {`SLM_IDX_W{1'b0}};
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLM_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_ok_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_ok_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[`SLM_IDX_W+1:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SLM_RESP_OKAY : `SLM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // commit once both halves are held and no answer is pending
  assign wr_go = aw_ok_r && w_ok_r && !s_axi_bvalid;
  // writable map; wstrb lane 0 gates the byte, others are ignored
  always @* begin
    case (aw_idx_r)
      `SLM_IDX_ERR_SEL, `SLM_IDX_DISP, `SLM_IDX_NIT, `SLM_IDX_UCC,
      `SLM_IDX_CGS, `SLM_IDX_FRS, `SLM_IDX_CKS, `SLM_IDX_IRQ_EN,
      `SLM_IDX_THR, `SLM_IDX_IRQ_CLR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // writes at shared addresses reach lane control only
  // action bits live for the commit cycle alone
  assign wr_disp = wr_go && wlane_r && (aw_idx_r == `SLM_IDX_DISP);
  assign wr_nit = wr_go && wlane_r && (aw_idx_r == `SLM_IDX_NIT);
  assign wr_ucc = wr_go && wlane_r && (aw_idx_r == `SLM_IDX_UCC);

  // bit 7 on a flag register clears its interrupt only
  assign flag_clr_cg = wr_go && wlane_r && (aw_idx_r == `SLM_IDX_CGS) &&
    wdata_r[`SLM_FLAG_IRQ_CLR];
  assign flag_clr_fr = wr_go && wlane_r && (aw_idx_r == `SLM_IDX_FRS) &&
    wdata_r[`SLM_FLAG_IRQ_CLR];
  assign flag_clr_ck = wr_go && wlane_r && (aw_idx_r == `SLM_IDX_CKS) &&
    wdata_r[`SLM_FLAG_IRQ_CLR];
  assign clr_bits = {flag_clr_ck, flag_clr_fr, flag_clr_cg} |
    ((wr_go && wlane_r && (aw_idx_r == `SLM_IDX_IRQ_CLR)) ?
    wdata_r[2:0] : 3'h0);

  // software settings: threshold, enables, counter selector
  always @(posedge aclk) begin
    if (!aresetn) begin
      thr_r <= `SLM_THR_RST;
      en_r <= `SLM_EN_RST;
      sel_r <= `SLM_SEL_RST;
    end else if (wr_go && wlane_r) begin
      if (aw_idx_r == `SLM_IDX_THR) begin
        thr_r <= wdata_r;
      end
      if (aw_idx_r == `SLM_IDX_IRQ_EN) begin
        en_r <= wdata_r;
      end
      if (aw_idx_r == `SLM_IDX_ERR_SEL) begin
        sel_r <= wdata_r;
      end
    end
  end

  // ==========================================
  // error counters, one instance per error type
  slm_err_type u_disp (
    .aclk(aclk),
    .aresetn(aresetn),
    .err_evt(bad_disparity_error),
    .ctl_we(wr_disp),
    .ctl_data(wdata_r),
    .thr(thr_r),
    .reach(disp_reach),
    .lane_irq(disp_irq),
    .counts(disp_cnt)
  );

  slm_err_type u_nit (
    .aclk(aclk),
    .aresetn(aresetn),
    .err_evt(not_in_table_error),
    .ctl_we(wr_nit),
    .ctl_data(wdata_r),
    .thr(thr_r),
    .reach(nit_reach),
    .lane_irq(nit_irq),
    .counts(nit_cnt)
  );

  slm_err_type u_ucc (
    .aclk(aclk),
    .aresetn(aresetn),
    .err_evt(unexpected_control_char_error),
    .ctl_we(wr_ucc),
    .ctl_data(wdata_r),
    .thr(thr_r),
    .reach(ucc_reach),
    .lane_irq(ucc_irq),
    .counts(ucc_cnt)
  );

  // ==========================================
  // link status and sync events
  // inputs come from same-clock lane logic, so no synchroniser
  assign cg_loss = |(cg_r & ~code_group_lock);
  assign fr_loss = |(fr_r & ~frame_lock);
  assign ck_bad = |(ck_r & ~checksum_ok);
  // live per-lane flags, one cycle late
  always @(posedge aclk) begin
    if (!aresetn) begin
      cg_r <= 8'h00;
      fr_r <= 8'h00;
      ck_r <= 8'h00;
    end else begin
      cg_r <= code_group_lock;
      fr_r <= frame_lock;
      ck_r <= checksum_ok;
    end
  end

  // sticky sync interrupt bits, a new event beats a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 3'h0;
    end else begin
      stat_r <= (stat_r & ~clr_bits) | {ck_bad, fr_loss, cg_loss};
    end
  end

  // request held while any lane lacks code-group lock
  // one-cycle resync kick on any frame-lock loss
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_request_n <= 1'b0;
      resync_start <= 1'b0;
    end else begin
      sync_request_n <= &code_group_lock;
      resync_start <= fr_loss;
    end
  end

  // ==========================================
  // interrupt combine
  assign stat_all = {|disp_irq, |nit_irq, |ucc_irq, 2'b00, stat_r};
  // enabled status pulls the active-low line down
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(|(stat_all & en_r));
    end
  end

  // ==========================================
  // read channel
  assign ar_idx = s_axi_araddr[`SLM_IDX_W+1:2];
  assign sel_base = {sel_r[`SLM_SEL_LANE_HI:`SLM_SEL_LANE_LO], 3'b000};
  // type code picks the counter bank, lane picks the byte
  assign sel_cnt =
    (sel_r[`SLM_SEL_TYPE_HI:`SLM_SEL_TYPE_LO] == `SLM_TYPE_DISP) ?
      disp_cnt[sel_base +: 8] :
    (sel_r[`SLM_SEL_TYPE_HI:`SLM_SEL_TYPE_LO] == `SLM_TYPE_NIT) ?
      nit_cnt[sel_base +: 8] :
    (sel_r[`SLM_SEL_TYPE_HI:`SLM_SEL_TYPE_LO] == `SLM_TYPE_UCC) ?
      ucc_cnt[sel_base +: 8] : 8'h00;

  // read mux; write-only clear register reads zero
  always @* begin
    rd_nxt = 8'h00;
    rd_hit = 1'b1;
    case (ar_idx)
      `SLM_IDX_ERR_SEL: rd_nxt = sel_cnt;
      `SLM_IDX_DISP: rd_nxt = disp_reach;
      `SLM_IDX_NIT: rd_nxt = nit_reach;
      `SLM_IDX_UCC: rd_nxt = ucc_reach;
      `SLM_IDX_CGS: rd_nxt = cg_r;
      `SLM_IDX_FRS: rd_nxt = fr_r;
      `SLM_IDX_CKS: rd_nxt = ck_r;
      `SLM_IDX_IRQ_EN: rd_nxt = en_r;
      `SLM_IDX_THR: rd_nxt = thr_r;
      `SLM_IDX_IRQ_STAT: rd_nxt = stat_all;
      `SLM_IDX_IRQ_CLR: rd_nxt = 8'h00;
      default: rd_hit = 1'b0;
    endcase
  end

  // single-cycle read answer; arready drops while rvalid waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SLM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_nxt};
        s_axi_rresp <= rd_hit ? `SLM_RESP_OKAY : `SLM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ---- dv/slm_link_model.sv ----
// link-side stand-in driving lane error pulses and lock levels
`default_nettype none
// ==========================================
// link model
module slm_link_model (
  input wire logic aclk,
  output logic [7:0] bad_disparity_error,
  output logic [7:0] not_in_table_error,
  output logic [7:0] unexpected_control_char_error,
  output logic [7:0] code_group_lock,
  output logic [7:0] frame_lock,
  output logic [7:0] checksum_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] err_r = 24'h0;
  // error types packed low to high: disparity, table miss, control char
  assign {unexpected_control_char_error, not_in_table_error, bad_disparity_error} = err_r;
  // idle link: every lane locked
  initial begin
    {code_group_lock, frame_lock, checksum_ok} = 24'hFFFFFF;
  end
  // back-to-back pulses, so each high cycle must count once
  task automatic burst(input int t, input int lane, input int n);
    repeat (n) begin
      @(posedge aclk);
      err_r <= 24'h1 << (8 * t + lane);
    end
    @(posedge aclk);
    err_r <= 24'h0;
  endtask
  // lock levels change only just after an edge
  task automatic locks(input logic [7:0] c, input logic [7:0] f, input logic [7:0] k);
    @(posedge aclk);
    code_group_lock <= c;
    frame_lock <= f;
    checksum_ok <= k;
  endtask
endmodule
`default_nettype wire

// ---- dv/slm_mon_checker.sv ----
// port-level assertions for the lane monitor
`default_nettype none
// ==========================================
// checker
module slm_mon_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] code_group_lock,
  input wire logic [7:0] frame_lock,
  input wire logic sync_request_n,
  input wire logic resync_start,
  input wire logic irq_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // past of reset guards edges whose history lies inside reset
  sync_req_a: assert property ($past(aresetn) |-> sync_request_n == &$past(code_group_lock))
    else $error("sync request does not follow lane lock");
  resync_go_a: assert property ($past(aresetn) && |($past(frame_lock) & ~frame_lock)
    |=> resync_start)
    else $error("frame loss without resync pulse");
  resync_cause_a: assert property (resync_start
    |-> ($past(frame_lock, 2) & ~$past(frame_lock)) != 8'h0)
    else $error("resync pulse without frame loss");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  aw_pulse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  c_resync: cover property (resync_start);
  c_sync: cover property (!sync_request_n);
  c_irq: cover property ($fell(irq_n));
endmodule
bind slm_lane_monitor slm_mon_checker i_slm_mon_checker (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .code_group_lock, .frame_lock, .sync_request_n,
  .resync_start, .irq_n);
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the lane monitor
`include "slm_consts.vh"
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
// ==========================================
// bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sync_request_n, resync_start, irq_n;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [7:0] bad_disparity_error, not_in_table_error, unexpected_control_char_error;
  logic [7:0] code_group_lock, frame_lock, checksum_ok, rdat;
  int fails = 0;
  int num_checks = 0;
  int n_resync = 0;
  slm_lane_monitor i_slm_lane_monitor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bad_disparity_error, .not_in_table_error, .unexpected_control_char_error,
    .code_group_lock, .frame_lock, .checksum_ok, .sync_request_n, .resync_start, .irq_n);
  slm_link_model i_slm_link_model (.aclk, .bad_disparity_error, .not_in_table_error,
    .unexpected_control_char_error, .code_group_lock, .frame_lock, .checksum_ok);
  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // resync pulses counted, a level stuck high shows as many
  always @(posedge aclk) begin
    if (resync_start === 1'b1) n_resync <= n_resync + 1;
  end
  // ==========================================
  // bus tasks
  task automatic wr(input logic [10:0] i, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {3'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] i);
    @(posedge aclk);
    s_axi_araddr <= {3'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rdat = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [10:0] i, input logic [7:0] e, input string n);
    rd(i);
    `CHK(n, e, rdat)
  endtask
  // irq output lags status and enable, so let it settle
  task automatic chk_irq(input logic e, input string n);
    repeat (3) @(posedge aclk);
    `CHK(n, e, irq_n)
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    `CHK("sync idle", 1'b1, sync_request_n)
    `CHK("irq idle", 1'b1, irq_n)
    rc(`SLM_IDX_THR, `SLM_THR_RST, "thr reset");
    rc(`SLM_IDX_IRQ_EN, `SLM_EN_RST, "enable reset");
    rc(`SLM_IDX_CGS, 8'hFF, "cg flags idle");
    rd(11'h400);
    `CHK("unmapped rresp", `SLM_RESP_SLVERR, resp)
    wr(11'h400, 8'hFF);
    `CHK("unmapped bresp", `SLM_RESP_SLVERR, resp)
    // byte lane 0 strobe off: answered, but nothing lands
    s_axi_wstrb <= 4'h0;
    wr(`SLM_IDX_THR, 8'h55);
    `CHK("no strobe bresp", `SLM_RESP_OKAY, resp)
    s_axi_wstrb <= 4'hF;
    rc(`SLM_IDX_THR, `SLM_THR_RST, "no strobe thr");
    $display("test regs done");
  endtask
  task automatic t_errs();
    logic [10:0] ci;
    wr(`SLM_IDX_THR, 8'h03);
    wr(`SLM_IDX_IRQ_EN, 8'hE0);
    for (int k = 0; k < 3; k++) begin
      ci = `SLM_IDX_DISP + 11'(k);
      i_slm_link_model.burst(k, 2, 2);
      rc(ci, 8'h00, "below thr");
      chk_irq(1'b1, "irq below thr");
      i_slm_link_model.burst(k, 2, 1);
      rc(ci, 8'h04, "at thr");
      chk_irq(1'b0, "irq at thr");
      wr(`SLM_IDX_ERR_SEL, {1'b0, 3'h2, 2'h0, k[1:0]});
      rc(`SLM_IDX_ERR_SEL, 8'h03, "count sel");
      wr(ci, 8'h82);
      chk_irq(1'b1, "irq cleared");
      wr(ci, 8'h25);
      rc(ci, 8'h04, "other lane clr");
      wr(ci, 8'h22);
      rc(ci, 8'h00, "count clr");
      i_slm_link_model.burst(k, 2, 3);
      wr(ci, 8'hA2);
      rc(`SLM_IDX_ERR_SEL, 8'h00, "repeat clr");
      chk_irq(1'b1, "irq repeat clr");
      wr(ci, 8'h42);
      i_slm_link_model.burst(k, 2, 3);
      rc(`SLM_IDX_ERR_SEL, 8'h00, "counter off");
    end
    // unused type code reads zero even with a live count behind it
    i_slm_link_model.burst(0, 4, 1);
    wr(`SLM_IDX_ERR_SEL, 8'h40);
    rc(`SLM_IDX_ERR_SEL, 8'h01, "lane4 count");
    wr(`SLM_IDX_ERR_SEL, 8'h43);
    rc(`SLM_IDX_ERR_SEL, 8'h00, "unused type");
    $display("test errs done");
  endtask
  task automatic t_sync();
    i_slm_link_model.locks(8'hDF, 8'hFF, 8'hFF);
    chk_irq(1'b1, "cg irq masked");
    `CHK("sync req", 1'b0, sync_request_n)
    rc(`SLM_IDX_CGS, 8'hDF, "cg flags");
    wr(`SLM_IDX_IRQ_EN, 8'h07);
    chk_irq(1'b0, "cg irq");
    wr(`SLM_IDX_CGS, 8'h80);
    chk_irq(1'b1, "cg irq clr");
    rc(`SLM_IDX_CGS, 8'hDF, "cg flags kept");
    i_slm_link_model.locks(8'hFF, 8'hFE, 8'hFF);
    chk_irq(1'b0, "frame irq");
    `CHK("sync released", 1'b1, sync_request_n)
    `CHK("resync count", 1, n_resync)
    rc(`SLM_IDX_FRS, 8'hFE, "frame flags");
    rc(`SLM_IDX_IRQ_STAT, 8'h02, "status");
    wr(`SLM_IDX_IRQ_CLR, 8'h02);
    chk_irq(1'b1, "frame irq clr");
    i_slm_link_model.locks(8'hFF, 8'hFE, 8'hF7);
    rc(`SLM_IDX_CKS, 8'hF7, "cks flags");
    chk_irq(1'b0, "cks irq");
    wr(`SLM_IDX_CKS, 8'h80);
    chk_irq(1'b1, "cks irq clr");
    $display("test sync done");
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog far beyond the expected run of a few hundred cycles
  initial begin
    #100us;
    fails++;
    $display("mismatch watchdog exp done got hang");
    report_and_stop();
  end
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_errs();
    t_sync();
    report_and_stop();
  end
endmodule
`default_nettype wire
